// >>> verilog/can_test_defines.svh
// register offsets, field positions and reset values of the test-mode block
`ifndef CAN_TEST_DEFINES_SVH
`define CAN_TEST_DEFINES_SVH

`define ADDR_W 8
`define OFS_MAIN_CTRL 8'h00
`define OFS_CTRL_STATUS 8'h02
`define OFS_TEST_CTRL 8'h0A
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_MASK 8'h21
`define OFS_IF1_DATA 8'h30
`define OFS_IF2_DATA 8'h31

`define MAIN_TEST_BIT 7
`define TEST_RX_BIT 7
`define TEST_OVR_HI 6
`define TEST_OVR_LO 5
`define TEST_LOOPBACK_ENABLE_BIT 4
`define TEST_SILENT_BIT 3
`define TEST_BASIC_BIT 2

`define ST_BUS_OFF_FLAG_BIT 7
`define ST_ERROR_WARNING_FLAG_BIT 6
`define ST_ERROR_PASSIVE_FLAG_BIT 5
`define ST_WR_MASK 8'h1F
`define ST_RECEIVE_OK_FLAG_BIT 4
`define ST_TRANSMIT_OK_FLAG_BIT 3
`define ST_LEC_HI 2
`define ST_LEC_LO 0

`define OVR_CORE 2'h0
`define OVR_SAMPLE 2'h1
`define OVR_DOMINANT 2'h2
`define OVR_RECESSIVE 2'h3

`define IRQ_RECEIVE_OK_FLAG_BIT 0
`define IRQ_TRANSMIT_OK_FLAG_BIT 1
`define IRQ_BUS_OFF_FLAG_BIT 2
`define IRQ_W 3

`define BYTE_ZERO 8'h00
`define IRQ_ZERO 3'h0
`define BUF_DEPTH 2

`endif

// >>> verilog/can_test_pkg.sv
// types shared by the test-mode block
`default_nettype none
package can_test_pkg;
    typedef struct packed {
        logic [1:0] tx_pin_override_select;
        logic loopback_enable;
        logic silent;
        logic basic;
    } test_cfg_s;

    typedef struct packed {
        logic bus_off_flag;
        logic error_warning_flag;
        logic error_passive_flag;
        logic receive_ok_flag;
        logic transmit_ok_flag;
        logic [2:0] last_error_code;
    } status_s;

    typedef enum logic [1:0] {
        OVR_CORE_E, OVR_SAMPLE_E, OVR_DOMINANT_E, OVR_RECESSIVE_E
    } override_e;
endpackage
`default_nettype wire

// >>> verilog/direct_buffer_mem.sv
// two-word buffer for direct-buffer mode, registered read data
`default_nettype none
module direct_buffer_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys, // system clock
    input wire logic we, // write enable
    input wire logic [$clog2(DEPTH)-1:0] waddr, // write index
    input wire logic [WIDTH-1:0] wdata, // write data
    input wire logic [$clog2(DEPTH)-1:0] raddr, // read index
    output logic [WIDTH-1:0] rdata // registered read data
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        rdata <= mem_r[raddr];
    end
endmodule
`default_nettype wire

// >>> verilog/can_test_mode.sv
// test-mode control, controller status register and direct buffer of the CAN controller
//
// Contract
// [RULE_01] override 00: transmit pin follows the protocol core; code holds it recessive while loopback or silent is set
// [RULE_02] override 01: transmit pin shows the internal sample point
// [RULE_03] override 10 forces dominant low, 11 forces recessive high
// [RULE_04] silent bit set: silent mode; clear: normal bus operation
// [RULE_05] bus-off, warning, passive read-only; rx-ok, tx-ok, error code writable
// [RULE_06] direct-buffer bit: first set transmits, second set receives, RAM bypassed
// [RULE_07] test control writes ignored unless main control test bit is set
// [RULE_08] test control bit 7 reads live receive pin, read-only
// [RULE_09] host clears test control before leaving test mode
`include "can_test_defines.svh"
`default_nettype none
module can_test_mode #(
    parameter int DATA_W = 8
) (
    input wire logic clk_sys, // system clock, 40 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic [`ADDR_W-1:0] addr, // register address
    input wire logic [DATA_W-1:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [DATA_W-1:0] rdata, // read data, cycle after rd
    input wire logic core_tx, // transmit level from protocol core
    input wire logic sample_point, // internal sample point strobe
    input wire logic bus_receive_pin, // receive pin level
    input wire logic core_bus_off, // core bus-off state
    input wire logic core_warning, // core error warning
    input wire logic core_passive, // core error passive
    input wire logic core_rx_ok, // pulse: frame received
    input wire logic core_tx_ok, // pulse: frame transmitted
    input wire logic core_lec_valid, // pulse: new error code
    input wire logic [2:0] core_lec, // error code value
    input wire logic [DATA_W-1:0] core_rx_byte, // received byte in direct-buffer mode
    output logic bus_transmit_pin, // transmit pin
    output logic core_rx, // receive level seen by the core
    output logic silent_mode, // core operates silent
    output logic loopback_mode, // core loops tx back internally
    output logic direct_buffer_mode, // message RAM bypassed
    output logic [DATA_W-1:0] core_tx_byte, // transmit byte from first set
    output logic irq // level interrupt
);
    logic [DATA_W-1:0] main_ctrl_r;
    can_test_pkg::test_cfg_s cfg_r;
    can_test_pkg::status_s status_r;
    logic [`IRQ_W-1:0] irq_status_r;
    logic [`IRQ_W-1:0] irq_mask_r;
    logic [`IRQ_W-1:0] irq_event;
    logic bus_off_flag_d_r;
    logic mem_rd_r;
    logic [DATA_W-1:0] reg_rdata_r;
    logic [DATA_W-1:0] mem_rdata;
    logic mem_we;
    logic mem_waddr;
    logic [DATA_W-1:0] mem_wdata;
    logic mem_raddr;
    logic tx_nxt;
    logic test_wr_ok;

    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    assign test_wr_ok = main_ctrl_r[`MAIN_TEST_BIT];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            main_ctrl_r <= `BYTE_ZERO;
        end else if (wr && hit(addr, `OFS_MAIN_CTRL)) begin
            main_ctrl_r <= wdata;
        end
    end

    // test settings only change while test access is enabled
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_r <= '0;
        end else if (wr && hit(addr, `OFS_TEST_CTRL) && test_wr_ok) begin // [RULE_07]
            cfg_r.tx_pin_override_select <= wdata[`TEST_OVR_HI:`TEST_OVR_LO];
            cfg_r.loopback_enable <= wdata[`TEST_LOOPBACK_ENABLE_BIT];
            cfg_r.silent <= wdata[`TEST_SILENT_BIT];
            cfg_r.basic <= wdata[`TEST_BASIC_BIT];
        end
    end

    // core flags mirror live state; host writes reach only the low five bits
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            status_r <= '0;
        end else begin
            status_r.bus_off_flag <= core_bus_off; // [RULE_05]
            status_r.error_warning_flag <= core_warning; // [RULE_05]
            status_r.error_passive_flag <= core_passive; // [RULE_05]
            if (core_rx_ok) begin
                status_r.receive_ok_flag <= 1'b1;
            end else if (wr && hit(addr, `OFS_CTRL_STATUS)) begin
                status_r.receive_ok_flag <= wdata[`ST_RECEIVE_OK_FLAG_BIT]; // [RULE_05]
            end
            if (core_tx_ok) begin
                status_r.transmit_ok_flag <= 1'b1;
            end else if (wr && hit(addr, `OFS_CTRL_STATUS)) begin
                status_r.transmit_ok_flag <= wdata[`ST_TRANSMIT_OK_FLAG_BIT]; // [RULE_05]
            end
            if (core_lec_valid) begin
                status_r.last_error_code <= core_lec;
            end else if (wr && hit(addr, `OFS_CTRL_STATUS)) begin
                status_r.last_error_code <= wdata[`ST_LEC_HI:`ST_LEC_LO]; // [RULE_05]
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_off_flag_d_r <= 1'b0;
        end else begin
            bus_off_flag_d_r <= core_bus_off;
        end
    end

    always_comb begin
        irq_event = `IRQ_ZERO;
        irq_event[`IRQ_RECEIVE_OK_FLAG_BIT] = core_rx_ok;
        irq_event[`IRQ_TRANSMIT_OK_FLAG_BIT] = core_tx_ok;
        irq_event[`IRQ_BUS_OFF_FLAG_BIT] = core_bus_off && !bus_off_flag_d_r;
    end

    // an event in the clearing cycle survives the clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_status_r <= `IRQ_ZERO;
        end else if (wr && hit(addr, `OFS_IRQ_STATUS)) begin
            irq_status_r <= (irq_status_r & ~wdata[`IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status_r <= irq_status_r | irq_event;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_mask_r <= `IRQ_ZERO;
        end else if (wr && hit(addr, `OFS_IRQ_MASK)) begin
            irq_mask_r <= wdata[`IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_r & irq_mask_r);
        end
    end

    // transmit pin select; loopback or silent keeps the bus recessive unless overridden
    always_comb begin
        unique case (can_test_pkg::override_e'(cfg_r.tx_pin_override_select))
            can_test_pkg::OVR_CORE_E: begin
                tx_nxt = (cfg_r.loopback_enable || cfg_r.silent) ? 1'b1 : core_tx; // [RULE_01]
            end
            can_test_pkg::OVR_SAMPLE_E: begin
                tx_nxt = sample_point; // [RULE_02]
            end
            can_test_pkg::OVR_DOMINANT_E: begin
                tx_nxt = 1'b0; // [RULE_03]
            end
            can_test_pkg::OVR_RECESSIVE_E: begin
                tx_nxt = 1'b1; // [RULE_03]
            end
        endcase
    end

    // registered pin adds one cycle of latency to the core's bit stream
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_transmit_pin <= 1'b1;
            core_rx <= 1'b1;
            silent_mode <= 1'b0;
            loopback_mode <= 1'b0;
            direct_buffer_mode <= 1'b0;
        end else begin
            bus_transmit_pin <= tx_nxt;
            core_rx <= cfg_r.loopback_enable ? core_tx : bus_receive_pin;
            silent_mode <= cfg_r.silent; // [RULE_04]
            loopback_mode <= cfg_r.loopback_enable;
            direct_buffer_mode <= cfg_r.basic; // [RULE_06]
        end
    end

    // word 0 is the first set (transmit), word 1 the second set (receive)
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = 1'b0;
        mem_wdata = wdata;
        if (cfg_r.basic && core_rx_ok) begin
            mem_we = 1'b1; // [RULE_06]
            mem_waddr = 1'b1;
            mem_wdata = core_rx_byte;
        end else if (wr && hit(addr, `OFS_IF1_DATA)) begin
            mem_we = 1'b1;
        end else if (wr && hit(addr, `OFS_IF2_DATA)) begin
            mem_we = 1'b1;
            mem_waddr = 1'b1;
        end
        mem_raddr = hit(addr, `OFS_IF2_DATA);
    end

    direct_buffer_mem #(
        .WIDTH(DATA_W),
        .DEPTH(`BUF_DEPTH)
    ) u_buf (
        .clk_sys(clk_sys),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            core_tx_byte <= `BYTE_ZERO;
        end else if (cfg_r.basic && wr && hit(addr, `OFS_IF1_DATA)) begin
            core_tx_byte <= wdata; // [RULE_06]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata_r <= `BYTE_ZERO;
            mem_rd_r <= 1'b0;
        end else begin
            mem_rd_r <= rd && (hit(addr, `OFS_IF1_DATA) || hit(addr, `OFS_IF2_DATA));
            reg_rdata_r <= `BYTE_ZERO;
            if (rd) begin
                unique case (addr)
                    `OFS_MAIN_CTRL: reg_rdata_r <= main_ctrl_r;
                    `OFS_CTRL_STATUS: reg_rdata_r <= status_r;
                    `OFS_TEST_CTRL: begin
                        reg_rdata_r <= {bus_receive_pin, cfg_r, 2'b00}; // [RULE_08]
                    end
                    `OFS_IRQ_STATUS: reg_rdata_r <= {5'h00, irq_status_r};
                    `OFS_IRQ_MASK: reg_rdata_r <= {5'h00, irq_mask_r};
                    default: reg_rdata_r <= `BYTE_ZERO;
                endcase
            end
        end
    end

    always_comb begin
        rdata = mem_rd_r ? mem_rdata : reg_rdata_r;
    end
endmodule
`default_nettype wire

// >>> tb/can_bus_model.sv
// far-side model: transceiver on a wired-and bus with one other node
`default_nettype none
module can_bus_model (
    input wire logic bus_transmit_pin, // our drive
    input wire logic other_dominant, // other node pulls low
    output logic bus_receive_pin // bus level
);
    timeunit 1ns / 1ps;
    // idle bus is recessive; any dominant driver wins
    assign bus_receive_pin = bus_transmit_pin & ~other_dominant;
endmodule
`default_nettype wire

// >>> tb/can_test_monitor.sv
// assertion checker for the test-mode block
`default_nettype none
module can_test_monitor (
    input wire logic clk_sys, // clock
    input wire logic srst, // reset
    input wire logic [7:0] addr, // address
    input wire logic [7:0] wdata, // data
    input wire logic wr, // write
    input wire logic rd, // read
    input wire logic [7:0] rdata, // read data
    input wire logic core_tx, // core level
    input wire logic sample_point, // sample
    input wire logic bus_receive_pin, // rx pin
    input wire logic core_bus_off, // bus-off
    input wire logic bus_transmit_pin, // tx pin
    input wire logic silent_mode, // silent
    input wire logic direct_buffer_mode // basic
);
    timeunit 1ns / 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic te_r;
    logic [4:0] cfg_r; // override, loopback, silent, basic
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            te_r <= 1'b0;
            cfg_r <= 5'h00;
        end else if (wr && addr == 8'h00) begin
            te_r <= wdata[7];
        end else if (wr && addr == 8'h0A && te_r) begin
            cfg_r <= wdata[6:2];
        end
    end
    sequence rd_ctl_s;
        rd && !srst && addr == 8'h0A;
    endsequence
    core_tx_a: assert property ($past(cfg_r[4:1]) == 4'h0 && !$past(srst)
        |-> bus_transmit_pin == $past(core_tx)) else $error("tx pin not core");
    sample_a: assert property ($past(cfg_r[4:3]) == 2'h1 && !$past(srst)
        |-> bus_transmit_pin == $past(sample_point)) else $error("tx pin not sample");
    force_a: assert property ($past(cfg_r[4]) && !$past(srst)
        |-> bus_transmit_pin == $past(cfg_r[3])) else $error("tx pin not forced");
    silent_a: assert property ($stable(cfg_r[1]) && !$past(srst)
        |-> silent_mode == cfg_r[1]) else $error("silent mode wrong");
    basic_a: assert property ($stable(cfg_r[0]) && !$past(srst)
        |-> direct_buffer_mode == cfg_r[0]) else $error("buffer mode wrong");
    status_ro_a: assert property (rd && !srst && addr == 8'h02
        |=> $past(srst, 2) || rdata[7] == $past(core_bus_off, 2)) else $error("bus-off bit");
    rx_read_a: assert property (rd_ctl_s
        |=> rdata[7] == $past(bus_receive_pin) && rdata[1:0] == 2'h0) else $error("rx bit");
    cfg_read_a: assert property (rd_ctl_s
        |=> rdata[6:2] == $past(cfg_r)) else $error("test bits wrong");
endmodule
`default_nettype wire

// >>> tb/can_test_mode_and_status_bench.sv
// self-checking bench of the test-mode block
`default_nettype none
module can_test_mode_and_status_bench;
    timeunit 1ns / 1ps;
    logic clk_sys = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, other_dominant = 1'b0;
    logic core_tx = 1'b1, sample_point = 1'b1, core_bus_off = 1'b0, core_warning = 1'b0;
    logic core_passive = 1'b0, core_rx_ok = 1'b0, core_tx_ok = 1'b0, core_lec_valid = 1'b0;
    logic [2:0] core_lec = 3'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, core_rx_byte = 8'h00, rdata, core_tx_byte;
    logic bus_receive_pin, bus_transmit_pin, core_rx, silent_mode, loopback_mode;
    logic direct_buffer_mode, irq;
    int n_mismatch = 0, checks = 0;
    can_test_mode i_dut (.clk_sys, .srst, .addr, .wdata, .wr, .rd, .rdata, .core_tx,
        .sample_point, .bus_receive_pin, .core_bus_off, .core_warning, .core_passive,
        .core_rx_ok, .core_tx_ok, .core_lec_valid, .core_lec, .core_rx_byte,
        .bus_transmit_pin, .core_rx, .silent_mode, .loopback_mode, .direct_buffer_mode,
        .core_tx_byte, .irq);
    can_bus_model i_bus (.bus_transmit_pin, .other_dominant, .bus_receive_pin);
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            n_mismatch++;
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        settle;
        rreg(8'h0A, 8'h80, "test_control");
        wreg(8'h0A, 8'h40);
        settle;
        chk("pin", 8'h01, 8'(bus_transmit_pin));
        rreg(8'h0A, 8'h80, "test_control");
        $display("test lock done");
        wreg(8'h00, 8'h80);
        for (int i = 0; i < 4; i++) begin
            wreg(8'h0A, 8'(i << 5));
            settle;
            rreg(8'h0A, {i != 2, 2'(i), 5'h00}, "test_control");
            for (int j = 0; j < 2; j++) begin
                @(posedge clk_sys);
                core_tx <= j[0];
                sample_point <= !j[0];
                settle;
                chk("pin", 8'(i == 0 ? j[0] : i == 1 ? !j[0] : i[0]), 8'(bus_transmit_pin));
            end
            sample_point <= 1'b1;
        end
        other_dominant <= 1'b1;
        rreg(8'h0A, 8'h60, "test_control");
        other_dominant <= 1'b0;
        $display("test override done");
        wreg(8'h0A, 8'h1C);
        core_tx <= 1'b0;
        settle;
        chk("modes", 8'h07, 8'({loopback_mode, silent_mode, direct_buffer_mode}));
        chk("pin", 8'h01, 8'(bus_transmit_pin));
        chk("core_rx", 8'h00, 8'(core_rx));
        wreg(8'h30, 8'hA5);
        settle;
        chk("core_tx_byte", 8'hA5, core_tx_byte);
        core_rx_ok <= 1'b1;
        core_rx_byte <= 8'h3C;
        @(posedge clk_sys);
        core_rx_ok <= 1'b0;
        rreg(8'h31, 8'h3C, "second_set");
        wreg(8'h0A, 8'h00);
        wreg(8'h00, 8'h00);
        core_tx <= 1'b1;
        settle;
        chk("modes", 8'h00, 8'({loopback_mode, silent_mode, direct_buffer_mode}));
        $display("test modes done");
        core_bus_off <= 1'b1;
        core_warning <= 1'b1;
        core_tx_ok <= 1'b1;
        core_lec_valid <= 1'b1;
        core_lec <= 3'h3;
        @(posedge clk_sys);
        core_tx_ok <= 1'b0;
        core_lec_valid <= 1'b0;
        settle;
        rreg(8'h02, 8'hDB, "status");
        wreg(8'h02, 8'h00);
        rreg(8'h02, 8'hC0, "status");
        core_bus_off <= 1'b0;
        core_warning <= 1'b0;
        core_passive <= 1'b1;
        settle;
        wreg(8'h02, 8'hFF);
        rreg(8'h02, 8'h3F, "status");
        $display("test status done");
        rreg(8'h20, 8'h07, "irq_status");
        chk("irq", 8'h00, 8'(irq));
        wreg(8'h21, 8'h02);
        settle;
        chk("irq", 8'h01, 8'(irq));
        wreg(8'h20, 8'h07);
        settle;
        chk("irq", 8'h00, 8'(irq));
        rreg(8'h20, 8'h00, "irq_status");
        rreg(8'h55, 8'h00, "unmapped");
        $display("test irq done");
        end_sim;
    end
endmodule
bind can_test_mode can_test_monitor i_mon (.clk_sys, .srst, .addr, .wdata, .wr, .rd, .rdata,
    .core_tx, .sample_point, .bus_receive_pin, .core_bus_off, .bus_transmit_pin,
    .silent_mode, .direct_buffer_mode);
`default_nettype wire
